// file: ppc_params.svh
// Constants of the receipt printer parallel port and switch decoder.
// Assumes a 200 MHz pclk; included by the port module.
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH
`define PPC_CLK_PERIOD_NS 5
`define PPC_T_MIN_NS      500
`define PPC_T_MIN_CYC     ((`PPC_T_MIN_NS + `PPC_CLK_PERIOD_NS - 1) / `PPC_CLK_PERIOD_NS)
`define PPC_T4_MAX_NS     270
`define PPC_T4_MAX_CYC    (`PPC_T4_MAX_NS / `PPC_CLK_PERIOD_NS)
`define PPC_T5_TYP_NS     2300
`define PPC_T5_CYC        (`PPC_T5_TYP_NS / `PPC_CLK_PERIOD_NS)
`define PPC_T6_MIN_MS     500
`define PPC_T6_CYC        ((`PPC_T6_MIN_MS * 1000000 + 4) / `PPC_CLK_PERIOD_NS)
`define PPC_RST_MIN_MS    1
`define PPC_RST_CYC       ((`PPC_RST_MIN_MS * 1000000 + 4) / `PPC_CLK_PERIOD_NS)
`define PPC_OFF_CTRL      8'h00
`define PPC_OFF_STATUS    8'h04
`define PPC_OFF_DATA      8'h08
`define PPC_OFF_CFG_A     8'h0c
`define PPC_OFF_CFG_B     8'h10
`define PPC_CTRL_ALARM    0
`define PPC_ST_OVERRUN    6
`define PPC_SWA_COLS      4
`define PPC_COLS_WIDE     6'h2c
`define PPC_COLS_NARROW   6'h2a
`define PPC_BAUD_BASE     15'h0096
`endif

// file: ppc_pkg.sv
// Types of the receipt printer parallel port.
// Uses nothing from ppc_params.svh; the widths that it shares with the port are written out here.
package ppc_pkg;
  typedef enum logic [2:0]
  {
    ppc_st_init = 3'b000,
    ppc_st_idle = 3'b001,
    ppc_st_hold = 3'b010,
    ppc_st_ack  = 3'b011,
    ppc_st_hrst = 3'b100
  } ppc_state_t;

  typedef struct packed {
    ppc_state_t  state;
    logic        strobe_q;
    logic        busy;
    logic        ack_n;
    logic [7:0]  data;
    logic        byte_valid;
    logic        overrun;
    logic [31:0] cnt;
    logic [31:0] rst_cnt;
    logic        alarm;
    logic        media;
    logic        drawer;
    logic        ctrl_alarm;
    logic [8:0]  cfg_a;
    logic [7:0]  cfg_b;
    logic [31:0] prdata;
  } ppc_regs_t;
endpackage : ppc_pkg

// file: ppc_port.sv
// Parallel host input port with busy/request handshake, status pins,
// switch-bank decoding and an APB register file.
// Assumes every input is synchronous to pclk and switch high means on, except bank A switch 1 (cover detect), which is on when low.
`include "ppc_params.svh"

module ppc_port #(
  parameter int unsigned POR_WAIT_CYCLES = `PPC_T6_CYC,
  parameter int unsigned HRST_MIN_CYCLES = `PPC_RST_CYC,
  parameter int unsigned ACK_CYCLES      = `PPC_T5_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Parallel host pins
  input  wire logic [7:0]  host_data,
  input  wire logic        data_strobe_n,
  input  wire logic        host_reset_n,
  output logic             busy,
  output logic             byte_request_n,
  output logic             alarm_out_n,
  output logic             media_out_flag,
  output logic             drawer_status,
  // Printer sensors
  input  wire logic        alarm_sense,
  input  wire logic        paper_end_sense,
  input  wire logic        paper_near_end_sense,
  input  wire logic        drawer_open_sense,
  // Configuration switches
  input  wire logic [9:0]  switch_bank_a,
  input  wire logic [7:0]  switch_bank_b,
  input  wire logic        serial_fitted,
  // Decoded printer settings
  output logic             cutter_enable,
  output logic             cover_detect_enable,
  output logic             cr_as_line_feed,
  output logic [5:0]       print_columns,
  output logic [2:0]       charset_code,
  output logic [1:0]       density_code,
  // Decoded serial settings
  output logic             serial_seven_bits,
  output logic             serial_parity_enable,
  output logic             serial_parity_even,
  output logic             serial_xon_xoff,
  output logic [2:0]       serial_baud_code,
  output logic [14:0]      serial_baud_rate
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The request pulse must cover the least handshake interval, and the
  // one-cycle answer to a strobe must fit inside the longest response.
  if (ACK_CYCLES < `PPC_T_MIN_CYC)
  begin : g_bad_ack
    $error("ACK_CYCLES shorter than the least handshake interval");
  end
  if (`PPC_T4_MAX_CYC < 1)
  begin : g_bad_t4
    $error("response limit below one clock cycle");
  end
  if (POR_WAIT_CYCLES < 2 || HRST_MIN_CYCLES < 1)
  begin : g_bad_cnt
    $error("wait counts must be at least two and one cycles");
  end

  localparam ppc_pkg::ppc_regs_t RST_VAL = '{
    state:    ppc_pkg::ppc_st_init,
    strobe_q: 1'b1,
    busy:     1'b1,
    ack_n:    1'b1,
    default:  '0
  };

  ppc_pkg::ppc_regs_t q;
  ppc_pkg::ppc_regs_t next_q;

  logic stb_fall;
  logic apb_setup;
  logic apb_wr;
  logic apb_rd;
  logic addr_hit;
  logic hrst_hit;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign stb_fall  = q.strobe_q & ~data_strobe_n;
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign apb_rd    = psel & penable & ~pwrite;
  assign hrst_hit  = ~host_reset_n && (q.rst_cnt >= 32'(HRST_MIN_CYCLES - 1));

  always_comb
  begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0;
    case (paddr)
      `PPC_OFF_CTRL:   rd_mux = {31'h0, q.ctrl_alarm};
      `PPC_OFF_STATUS: rd_mux = {25'h0, q.overrun, q.drawer, q.media, q.alarm,
                                 (q.state != ppc_pkg::ppc_st_init), q.byte_valid,
                                 q.busy};
      `PPC_OFF_DATA:   rd_mux = {24'h0, q.data};
      `PPC_OFF_CFG_A:  rd_mux = {23'h0, q.cfg_a};
      `PPC_OFF_CFG_B:  rd_mux = {24'h0, q.cfg_b};
      default:         addr_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_q          = q;
    next_q.strobe_q = data_strobe_n;
    next_q.alarm    = alarm_sense | q.ctrl_alarm;
    next_q.media    = paper_end_sense | paper_near_end_sense;
    next_q.drawer   = drawer_open_sense;

    // Read data is latched in the setup phase so that it leaves a flop.
    if (apb_setup)
    begin
      next_q.prdata = rd_mux;
    end
    if (apb_wr && paddr == `PPC_OFF_CTRL)
    begin
      next_q.ctrl_alarm = pwdata[`PPC_CTRL_ALARM];
    end
    if (apb_wr && paddr == `PPC_OFF_STATUS && pwdata[`PPC_ST_OVERRUN])
    begin
      next_q.overrun = 1'b0;
    end

    // The reset pin only counts as a reset once it is held long enough.
    if (!host_reset_n)
    begin
      if (q.rst_cnt != 32'hffffffff)
      begin
        next_q.rst_cnt = q.rst_cnt + 32'h1;
      end
    end
    else
    begin
      next_q.rst_cnt = 32'h0;
    end

    // A strobe while busy is lost; the flag records it, set over clear.
    if (stb_fall && q.busy)
    begin
      next_q.overrun = 1'b1;
    end

    if (hrst_hit)
    begin
      next_q.state      = ppc_pkg::ppc_st_hrst;
      next_q.busy       = 1'b1;
      next_q.ack_n      = 1'b1;
      next_q.byte_valid = 1'b0;
      next_q.overrun    = 1'b0;
      next_q.ctrl_alarm = 1'b0;
      next_q.alarm      = alarm_sense;
    end
    else if (q.alarm)
    begin
      // The handshake state and counter are frozen and busy is held high while the alarm lasts.
      next_q.busy = 1'b1;
    end
    else
    begin
      case (q.state)
        ppc_pkg::ppc_st_init:
        begin
          next_q.busy = 1'b1;
          next_q.cnt  = q.cnt + 32'h1;
          if (q.cnt == 32'(POR_WAIT_CYCLES - 1))
          begin
            next_q.state = ppc_pkg::ppc_st_idle;
            next_q.busy  = 1'b0;
            next_q.cnt   = 32'h0;
          end
        end
        ppc_pkg::ppc_st_idle:
        begin
          next_q.busy = 1'b0;
          if (stb_fall)
          begin
            next_q.data       = host_data;
            next_q.byte_valid = 1'b1;
            next_q.busy       = 1'b1;
            next_q.state      = ppc_pkg::ppc_st_hold;
          end
        end
        ppc_pkg::ppc_st_hold:
        begin
          next_q.busy = 1'b1;
          if (apb_rd && paddr == `PPC_OFF_DATA)
          begin
            next_q.byte_valid = 1'b0;
            next_q.ack_n      = 1'b0;
            next_q.cnt        = 32'h0;
            next_q.state      = ppc_pkg::ppc_st_ack;
          end
        end
        ppc_pkg::ppc_st_ack:
        begin
          next_q.busy = 1'b1;
          next_q.cnt  = q.cnt + 32'h1;
          if (q.cnt == 32'(ACK_CYCLES - 1))
          begin
            // The pulse ends in the cycle in which busy falls.
            next_q.ack_n = 1'b1;
            next_q.busy  = 1'b0;
            next_q.cnt   = 32'h0;
            next_q.state = ppc_pkg::ppc_st_idle;
          end
        end
        ppc_pkg::ppc_st_hrst:
        begin
          next_q.busy = 1'b1;
          if (host_reset_n)
          begin
            next_q.busy  = 1'b0;
            next_q.state = ppc_pkg::ppc_st_idle;
          end
        end
        default:
        begin
          next_q.state = ppc_pkg::ppc_st_init;
          next_q.busy  = 1'b1;
          next_q.cnt   = 32'h0;
        end
      endcase
    end

    // Switches are followed only in the reset states, then held.
    if (next_q.state == ppc_pkg::ppc_st_init || next_q.state == ppc_pkg::ppc_st_hrst)
    begin
      next_q.cfg_a = {switch_bank_a[9:8],
                      switch_bank_a[7:5],
                      switch_bank_a[`PPC_SWA_COLS],
                      switch_bank_a[2],
                      ~switch_bank_a[1],
                      switch_bank_a[0]};
      next_q.cfg_b = serial_fitted ? {1'b1, switch_bank_b[6:0]} : 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= RST_VAL;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata               = q.prdata;
  assign pready               = psel & penable;
  assign pslverr              = psel & penable & ~addr_hit;
  assign busy                 = q.busy;
  assign byte_request_n       = q.ack_n;
  assign alarm_out_n          = ~q.alarm;
  assign media_out_flag       = q.media;
  assign drawer_status        = q.drawer;
  assign cutter_enable        = q.cfg_a[0];
  assign cover_detect_enable  = q.cfg_a[1];
  assign cr_as_line_feed      = q.cfg_a[2];
  assign print_columns        = q.cfg_a[3] ? `PPC_COLS_WIDE : `PPC_COLS_NARROW;
  assign charset_code         = q.cfg_a[6:4];
  assign density_code         = q.cfg_a[8:7];
  assign serial_seven_bits    = q.cfg_b[0];
  assign serial_parity_enable = q.cfg_b[1];
  assign serial_parity_even   = q.cfg_b[2];
  assign serial_xon_xoff      = q.cfg_b[3];
  assign serial_baud_code     = q.cfg_b[6:4];
  assign serial_baud_rate     = 15'(`PPC_BAUD_BASE << q.cfg_b[6:4]);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [31:0] ack_len;

  // Counts the running cycles of the request pulse; an alarm halts it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_len <= 32'h0;
    end
    else
    begin
      ack_len <= byte_request_n ? 32'h0 : ack_len + {31'h0, ~q.alarm};
    end
  end

  chk_strobe_capture: assert property (
    (q.state == ppc_pkg::ppc_st_idle && stb_fall && !q.alarm && !hrst_hit)
    |=> busy && q.byte_valid && q.data == $past(host_data))
    else $error("strobed byte not captured with busy");

  chk_busy_while_held: assert property (
    q.byte_valid |-> busy)
    else $error("busy low while a byte is held");

  chk_ack_pulse_width: assert property (
    ($rose(byte_request_n) && !$past(hrst_hit)) |-> ack_len == 32'(ACK_CYCLES))
    else $error("request pulse has the wrong width");

  chk_ack_frees_busy: assert property (
    ($rose(byte_request_n) && !$past(hrst_hit))
    |-> $fell(busy) && q.state == ppc_pkg::ppc_st_idle)
    else $error("request pulse end not paired with busy release");

  chk_alarm_halts: assert property (
    (q.alarm && $past(q.alarm) && !$past(hrst_hit))
    |-> !alarm_out_n && busy && $stable(q.state) && $stable(q.cnt))
    else $error("control moved during alarm");

  chk_media_out: assert property (
    ##1 media_out_flag == $past(paper_end_sense | paper_near_end_sense))
    else $error("media-out flag does not follow the paper sensors");

  chk_drawer_state: assert property (
    ##1 drawer_status == $past(drawer_open_sense))
    else $error("drawer status does not follow the switch");

  chk_por_wait: assert property (
    (q.state == ppc_pkg::ppc_st_idle && $past(q.state) == ppc_pkg::ppc_st_init)
    |-> $past(q.cnt) == 32'(POR_WAIT_CYCLES - 1) && !busy)
    else $error("power-on wait ended early or late");

  chk_init_busy: assert property (
    (q.state == ppc_pkg::ppc_st_init || q.state == ppc_pkg::ppc_st_hrst) |-> busy)
    else $error("busy low before initialisation ends");

  chk_host_reset: assert property (
    $past(hrst_hit) |-> q.state == ppc_pkg::ppc_st_hrst && !q.byte_valid && busy)
    else $error("long reset pulse did not reset the port");

  chk_cfg_frozen: assert property (
    (q.state == $past(q.state) && q.state != ppc_pkg::ppc_st_init
     && q.state != ppc_pkg::ppc_st_hrst && !$past(hrst_hit))
    |-> $stable(q.cfg_a) && $stable(q.cfg_b))
    else $error("settings changed outside reset");

  chk_bank_b_gate: assert property (
    (next_q.state == ppc_pkg::ppc_st_init && !serial_fitted) |=> q.cfg_b == 8'h00)
    else $error("serial settings taken without serial interface");

  chk_lost_byte: assert property (
    (stb_fall && busy && !hrst_hit) |=> q.overrun)
    else $error("strobe during busy not flagged");

endmodule : ppc_port

// file: ppc_host_model.sv
// Host computer model that drives the printer's parallel input pins.
// Assumes a 200 MHz pclk; the testbench calls its tasks.
module ppc_host_model #(
  parameter int T_MIN = 100
) (
  // Clock
  input  wire logic       pclk,
  // Printer pins
  input  wire logic       busy,
  output logic [7:0]      host_data,
  output logic            data_strobe_n,
  output logic            host_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int resp_cyc;

  // Released data lines float to their pull-up level.
  initial
  begin
    host_data = 8'hff;
    data_strobe_n = 1'b1;
    host_reset_n = 1'b1;
  end

  task automatic send(input logic [7:0] b, input bit force_it);
    while (!force_it && busy !== 1'b0) @(posedge pclk);
    host_data <= b;
    repeat (T_MIN) @(posedge pclk);
    data_strobe_n <= 1'b0;
    resp_cyc = -1;
    for (int i = 0; i < T_MIN; i++)
    begin
      @(posedge pclk);
      if (busy === 1'b1 && resp_cyc < 0) resp_cyc = i;
    end
    data_strobe_n <= 1'b1;
    repeat (T_MIN) @(posedge pclk);
    host_data <= 8'hff;
    // The released lines stand for one edge before the next byte may be set.
    @(posedge pclk);
  endtask : send

  task automatic reset_pulse(input int n);
    host_reset_n <= 1'b0;
    repeat (n) @(posedge pclk);
    host_reset_n <= 1'b1;
    @(posedge pclk);
  endtask : reset_pulse
endmodule : ppc_host_model

// file: ppc_port_tb.sv
// Self-checking testbench of the printer parallel port.
// Assumes ppc_port and ppc_host_model; shortened counts by parameter.
`define CHECK(g, e) begin n_checks++; if ((g) !== (e)) report(g, e); end
module ppc_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 20;
  localparam int HRST = 8;
  localparam int ACK = 100;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic pready, pslverr, rerr, busy, byte_request_n, alarm_out_n;
  logic media_out_flag, drawer_status, host_reset_n, data_strobe_n;
  logic [7:0] host_data;
  logic alarm_sense = 0, paper_end_sense = 0, paper_near_end_sense = 0;
  logic drawer_open_sense = 0, serial_fitted = 0;
  logic [9:0] switch_bank_a = 0;
  logic [7:0] switch_bank_b = 0;
  logic cutter_enable, cover_detect_enable, cr_as_line_feed;
  logic [5:0] print_columns;
  logic [2:0] charset_code, serial_baud_code;
  logic [1:0] density_code;
  logic serial_seven_bits, serial_parity_enable, serial_parity_even, serial_xon_xoff;
  logic [14:0] serial_baud_rate;
  int fails = 0, n_checks = 0;

  always #2.5 pclk = ~pclk;

  ppc_port #(.POR_WAIT_CYCLES(POR), .HRST_MIN_CYCLES(HRST), .ACK_CYCLES(ACK)) ppc_port_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .host_data, .data_strobe_n, .host_reset_n, .busy, .byte_request_n,
    .alarm_out_n, .media_out_flag, .drawer_status, .alarm_sense, .paper_end_sense,
    .paper_near_end_sense, .drawer_open_sense, .switch_bank_a, .switch_bank_b,
    .serial_fitted, .cutter_enable, .cover_detect_enable, .cr_as_line_feed,
    .print_columns, .charset_code, .density_code, .serial_seven_bits,
    .serial_parity_enable, .serial_parity_even, .serial_xon_xoff, .serial_baud_code,
    .serial_baud_rate);

  ppc_host_model ppc_host_model_i (
    .pclk, .busy, .host_data, .data_strobe_n, .host_reset_n);

  task automatic report(input logic [31:0] g, input logic [31:0] e);
    fails++;
    $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
  endtask : report

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHECK({busy, byte_request_n, alarm_out_n}, 3'h7);
    presetn <= 1'b1;
    repeat (POR - 2) @(posedge pclk);
    `CHECK(busy, 1'b1);
    repeat (4) @(posedge pclk);
    `CHECK(busy, 1'b0);
  endtask : do_reset

  // Counts the request pulse after a DATA read and checks busy at its end.
  task automatic count_pulse;
    int n = 0;
    int k = 0;
    while (byte_request_n !== 1'b0 && k < 5)
    begin
      @(posedge pclk);
      k++;
    end
    while (byte_request_n === 1'b0 && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
    `CHECK(n, ACK);
    `CHECK(busy, 1'b0);
  endtask : count_pulse

  task automatic t_switches;
    logic f;
    for (int i = 0; i < 8; i++)
    begin
      f = (i != 7);
      switch_bank_a <= {i[1:0], i[2:0], i[0], 1'b0, i[1], i[2], ~i[0]};
      switch_bank_b <= {1'b0, i[2:0], i[0], i[1], i[2], ~i[0]};
      serial_fitted <= f;
      do_reset();
      `CHECK(cutter_enable, ~i[0]);
      `CHECK(cover_detect_enable, ~i[2]);
      `CHECK(cr_as_line_feed, i[1]);
      `CHECK(print_columns, i[0] ? 6'h2c : 6'h2a);
      `CHECK(charset_code, i[2:0]);
      `CHECK(density_code, i[1:0]);
      `CHECK(serial_baud_code, f ? i[2:0] : 3'h0);
      `CHECK(serial_baud_rate, f ? 15'h0096 << i : 15'h0096);
      `CHECK({serial_xon_xoff, serial_parity_even, serial_parity_enable,
              serial_seven_bits}, f ? {i[0], i[1], i[2], ~i[0]} : 4'h0);
      switch_bank_a <= ~switch_bank_a;
      switch_bank_b <= ~switch_bank_b;
      repeat (3) @(posedge pclk);
      `CHECK({density_code, charset_code, cutter_enable}, {i[1:0], i[2:0], ~i[0]});
    end
    $display("test switches done");
  endtask : t_switches

  task automatic t_bytes;
    logic [7:0] b;
    for (int i = 0; i < 2; i++)
    begin
      b = i ? 8'h5a : 8'ha5;
      ppc_host_model_i.send(b, 1'b0);
      `CHECK(ppc_host_model_i.resp_cyc inside {[0:54]}, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      `CHECK(rdata, {24'h0, b});
      count_pulse();
    end
    $display("test bytes done");
  endtask : t_bytes

  task automatic t_refuse;
    ppc_host_model_i.send(8'h3c, 1'b0);
    ppc_host_model_i.send(8'hc3, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    `CHECK({rdata[6], rdata[0]}, 2'h3);
    apb(1'b0, 8'h08, 32'h0);
    `CHECK(rdata, 32'h3c);
    count_pulse();
    apb(1'b1, 8'h04, 32'h40);
    apb(1'b0, 8'h04, 32'h0);
    `CHECK(rdata[6], 1'b0);
    apb(1'b1, 8'h14, 32'hffff);
    `CHECK(rerr, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    `CHECK({rerr, rdata}, {1'b1, 32'h0});
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_alarm;
    alarm_sense <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHECK({alarm_out_n, busy}, 2'h1);
    ppc_host_model_i.send(8'h77, 1'b1);
    alarm_sense <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHECK({alarm_out_n, busy}, 2'h2);
    apb(1'b0, 8'h04, 32'h0);
    `CHECK(rdata[1], 1'b0);
    apb(1'b1, 8'h04, 32'h40);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge pclk);
    `CHECK(alarm_out_n, 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    repeat (2) @(posedge pclk);
    `CHECK(alarm_out_n, 1'b1);
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_sense;
    for (int i = 0; i < 8; i++)
    begin
      {drawer_open_sense, paper_near_end_sense, paper_end_sense} <= i[2:0];
      repeat (2) @(posedge pclk);
      `CHECK(media_out_flag, i[0] | i[1]);
      `CHECK(drawer_status, i[2]);
    end
    $display("test sense done");
  endtask : t_sense

  task automatic t_host_reset;
    ppc_host_model_i.send(8'h11, 1'b0);
    ppc_host_model_i.reset_pulse(HRST - 4);
    repeat (3) @(posedge pclk);
    `CHECK(busy, 1'b1);
    ppc_host_model_i.reset_pulse(HRST + 4);
    repeat (3) @(posedge pclk);
    `CHECK(busy, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    `CHECK(rdata[1], 1'b0);
    $display("test host reset done");
  endtask : t_host_reset

  initial
  begin
    t_switches();
    t_bytes();
    t_refuse();
    t_alarm();
    t_sense();
    t_host_reset();
    end_of_test();
  end

  initial
  begin
    repeat (30000) @(posedge pclk);
    fails++;
    end_of_test();
  end
endmodule : ppc_port_tb
